// [ahs_defines.vh]
`ifndef AHS_DEFINES_VH
`define AHS_DEFINES_VH

// ----------------------------------------------------------------------
// register port
// ----------------------------------------------------------------------
`define AHS_AW 4
`define AHS_DW 16
`define AHS_ZERO16 16'h0000
`define AHS_A_CMD 4'h0
`define AHS_A_MAIN 4'h0
`define AHS_A_ST1 4'h1
`define AHS_A_MODEB 4'h1
`define AHS_A_ST2 4'h2
`define AHS_A_MODEA 4'h2
`define AHS_A_ST3 4'h3
`define AHS_A_OFS 4'h3
`define AHS_A_LCFG 4'h4

// ----------------------------------------------------------------------
// command word
// ----------------------------------------------------------------------
`define AHS_CMD_MSB 6
`define AHS_AXIS_LSB 8
`define AHS_CMD_START 7'h62
`define AHS_CMD_STOP_DEC 7'h26
`define AHS_CMD_STOP_INS 7'h27
`define AHS_CMD_CLR_STAT 7'h25
`define AHS_CMD_DRV_LO 7'h20
`define AHS_CMD_DRV_HI 7'h23

// ----------------------------------------------------------------------
// extension mode word b and a
// ----------------------------------------------------------------------
`define AHS_MB_W 10
`define AHS_ST1E 0
`define AHS_ST1D 1
`define AHS_ST2E 2
`define AHS_ST2D 3
`define AHS_ST3E 4
`define AHS_ST3D 5
`define AHS_ST4E 6
`define AHS_ST4D 7
`define AHS_COUNTER_CLEAR_AT_END 8
`define AHS_COMBINED_INDEX_STOP 9
`define AHS_SEARCH_DONE_IRQ_ENABLE 5

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define AHS_ERR_SHIFT 4
`define AHS_E_LIMP 2
`define AHS_E_LIMM 3
`define AHS_E_ALM 4
`define AHS_E_EMG 5
`define AHS_E_HOME 7
`define AHS_SC_LSB 8
`define AHS_SC_MSB 12
`define AHS_S1_LIMP 12
`define AHS_S1_LIMM 13
`define AHS_S1_ALM 14
`define AHS_S1_EMG 15
`define AHS_S3_DONE 8

// ----------------------------------------------------------------------
// execution state codes
// ----------------------------------------------------------------------
`define AHS_SC_IDLE 5'h00
`define AHS_SC_S1 5'h03
`define AHS_SC_S2A 5'h08
`define AHS_SC_S2B 5'h0C
`define AHS_SC_S2C 5'h0F
`define AHS_SC_S3 5'h14
`define AHS_SC_S4 5'h19

`endif

// [ahs_input_sync.v]
`timescale 1ns/1ps
`default_nettype none
module ahs_input_sync #(
  parameter W = 7
) (
  input wire clk_i, // system clock
  input wire resetn_i, // async reset, active low
  input wire [W-1:0] async_i, // pin levels
  output reg [W-1:0] sync_o // filtered levels
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar g;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync_o[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          sync_o[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule // ahs_input_sync
`default_nettype wire

// [ahs_offset_count.v]
`timescale 1ns/1ps
`default_nettype none
module ahs_offset_count #(
  parameter W = 16
) (
  input wire clk_i, // system clock
  input wire resetn_i, // async reset, active low
  input wire load_i, // start offset run
  input wire pulse_i, // one output pulse issued
  input wire [W-1:0] ofs_i, // pulses to drive
  output reg done_o // offset reached
);
  reg [W-1:0] cnt_r;
  reg act_r;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= {W{1'b0}};
      act_r <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_r <= ofs_i;
      act_r <= 1'b1;
      done_o <= 1'b0;
    end else begin
      if (pulse_i && cnt_r != {W{1'b0}}) begin
        cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
      done_o <= act_r && cnt_r == {W{1'b0}};
    end
  end
endmodule // ahs_offset_count
`default_nettype wire

// [ahs_pulse_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ahs_pulse_model (
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic run_i, // motion requested
  input wire logic slow_i, // 1: one pulse every 4 cycles
  output logic pulse_o // one pulse issued
);
  logic [1:0] cnt_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 2'h0;
      pulse_o <= 1'b0;
    end else begin
      cnt_r <= run_i ? cnt_r + 2'h1 : 2'h0;
      pulse_o <= run_i && (slow_i ? cnt_r == 2'h3 : cnt_r[0]);
    end
  end
endmodule // ahs_pulse_model
`default_nettype wire

// [ahs_sequencer.v]
//Contract
// R1 - command 62h with this axis selected starts the search sequence
// R2 - stop command 26h or 27h ends the whole search at once
// R3 - busy bit is 1 from search start until the search terminates
// R4 - host checks error bits only after the search has finished
// R5 - second status holds error flags low, state code in bits 12..8
// R6 - index already active when step 3 begins sets the early-index flag
// R7 - early-index flag clears on drive, search start or 25h command
// R8 - state code 0 while idle, 3 during step 1
// R9 - step 2 codes: 8 reverse seek, 12 reverse leave, 15 forward seek
// R10 - state code 20 during step 3, 25 during step 4 offset
// R11 - alarm stops instantly, ends search, sets alarm flags
// R12 - emergency stop stops instantly, ends search, sets flags
// R13 - limit in step 3 stops as configured, ends, sets limit flags
// R14 - limit in step 4 stops offset as configured, ends, sets flags
// R15 - early index ends search before step 3 and flags an error
// R16 - near-home already active at start skips step 1
// R17 - search-direction limit in step 1 moves on to reversing step 2
// R18 - step 2 reverses at forward limit, opposite limit ends with error
// R19 - each step runs only if enabled; direction bit 1 means minus
// R20 - counter-clear bit clears position counters when step 4 ends
// R21 - done interrupt drives output low, status-three read releases
// R22 - combined mode stops step 3 only on home and index together
// R23 - after any end the state code returns to 0, axis idles
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ahs_defines.vh"
module ahs_sequencer #(
  parameter AXIS_IDX = 0,
  parameter OFS_W = 16
) (
  input wire clk_i, // 20 MHz system clock
  input wire resetn_i, // async reset, active low
  input wire [`AHS_AW-1:0] reg_addr_i, // register address
  input wire [`AHS_DW-1:0] reg_wdata_i, // write data
  input wire reg_we_i, // write strobe
  input wire reg_re_i, // read strobe
  output reg [`AHS_DW-1:0] reg_rdata_o, // read data, next cycle
  input wire near_home_input_i, // near-home sensor, 1 active
  input wire home_position_input_i, // home sensor, 1 active
  input wire encoder_index_input_i, // encoder index, 1 active
  input wire servo_alarm_i, // servo alarm, 1 active
  input wire emergency_stop_input_i, // emergency stop, 1 active
  input wire plus_limit_input_i, // plus limit, 1 active
  input wire minus_limit_input_i, // minus limit, 1 active
  input wire drive_pulse_i, // one pulse issued by generator
  output reg drive_run_o, // request motion
  output reg drive_dir_o, // 0 plus, 1 minus
  output reg drive_fast_o, // 1 drive speed, 0 search speed
  output reg stop_instant_o, // pulse: instant stop
  output reg stop_decel_o, // pulse: decelerating stop
  output reg counter_clear_o, // pulse: clear both position counters
  output reg interrupt_out_n_o, // interrupt pin level, low
  output reg interrupt_oe_o // interrupt pin driven
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'b0000001;
  localparam [6:0] ST_S1 = 7'b0000010;
  localparam [6:0] ST_S2A = 7'b0000100;
  localparam [6:0] ST_S2B = 7'b0001000;
  localparam [6:0] ST_S2C = 7'b0010000;
  localparam [6:0] ST_S3 = 7'b0100000;
  localparam [6:0] ST_S4 = 7'b1000000;

  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg [`AHS_MB_W-1:0] modeb_r;
  reg search_done_irq_enable_r;
  reg [OFS_W-1:0] ofs_r;
  reg lcfg_decel_r;
  reg [7:0] err_r;
  reg [3:0] st1_r;
  reg done_r;
  reg [`AHS_DW-1:0] rd_nxt;

  wire near_s;
  wire home_s;
  wire idx_s;
  wire alm_s;
  wire emg_s;
  wire limp_s;
  wire limm_s;
  wire ofs_done;

  ahs_input_sync #(
    .W(7)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({near_home_input_i, home_position_input_i,
      encoder_index_input_i, servo_alarm_i, emergency_stop_input_i,
      plus_limit_input_i, minus_limit_input_i}),
    .sync_o({near_s, home_s, idx_s, alm_s, emg_s, limp_s, limm_s})
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function is_cmd;
    input [`AHS_CMD_MSB:0] c;
    input [`AHS_CMD_MSB:0] k;
    begin
      is_cmd = (c == k);
    end
  endfunction

  // direction of the step a state belongs to; reversal inverts step 2
  function step_dir;
    input [6:0] s;
    input [`AHS_MB_W-1:0] m;
    begin
      step_dir = 1'b0;
      case (s)
        ST_S1: step_dir = m[`AHS_ST1D];
        ST_S2A: step_dir = ~m[`AHS_ST2D];
        ST_S2B: step_dir = ~m[`AHS_ST2D];
        ST_S2C: step_dir = m[`AHS_ST2D];
        ST_S3: step_dir = m[`AHS_ST3D];
        ST_S4: step_dir = m[`AHS_ST4D];
        default: step_dir = 1'b0;
      endcase
    end
  endfunction

  // first enabled step from lvl on; bit 7 marks early index
  function [7:0] pick;
    input [2:0] lvl;
    input [`AHS_MB_W-1:0] m;
    input near;
    input home;
    input idx;
    reg [6:0] s;
    reg e;
    begin
      s = ST_IDLE;
      e = 1'b0;
      if (lvl <= 3'd1 && m[`AHS_ST1E] && !near) begin // R16 R19
        s = ST_S1;
      end else if (lvl <= 3'd2 && m[`AHS_ST2E]) begin // R19
        s = home ? ST_S2B : ST_S2C;
      end else if (lvl <= 3'd3 && m[`AHS_ST3E]) begin // R19
        if (idx) begin
          e = 1'b1; // R6 R15
        end else begin
          s = ST_S3;
        end
      end else if (m[`AHS_ST4E]) begin // R19
        s = ST_S4;
      end
      pick = {e, s};
    end
  endfunction

  // --------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------
  wire [`AHS_CMD_MSB:0] cmd = reg_wdata_i[`AHS_CMD_MSB:0];
  wire cmd_wr = reg_we_i && (reg_addr_i == `AHS_A_CMD) &&
    reg_wdata_i[`AHS_AXIS_LSB + AXIS_IDX];
  wire busy = ~state_r[0];
  wire c_start = cmd_wr && is_cmd(cmd, `AHS_CMD_START);
  wire c_sdec = cmd_wr && is_cmd(cmd, `AHS_CMD_STOP_DEC);
  wire c_sins = cmd_wr && is_cmd(cmd, `AHS_CMD_STOP_INS);
  wire c_clr = cmd_wr && is_cmd(cmd, `AHS_CMD_CLR_STAT);
  wire c_drv = cmd_wr && (cmd >= `AHS_CMD_DRV_LO) &&
    (cmd <= `AHS_CMD_DRV_HI);
  wire cur_dir = step_dir(state_r, modeb_r);
  wire lim_fwd = cur_dir ? limm_s : limp_s;
  wire lim_any = limp_s | limm_s;
  wire s3_hit = modeb_r[`AHS_COMBINED_INDEX_STOP] ? (home_s & idx_s) : idx_s; // R22

  // --------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------
  reg fin;
  reg fin_s4;
  reg set_alm;
  reg set_emg;
  reg set_lp;
  reg set_lm;
  reg set_home;
  reg stop_i;
  reg stop_d;
  reg [7:0] pk;

  always @* begin
    state_nxt = state_r;
    fin = 1'b0;
    fin_s4 = 1'b0;
    set_alm = 1'b0;
    set_emg = 1'b0;
    set_lp = 1'b0;
    set_lm = 1'b0;
    set_home = 1'b0;
    stop_i = 1'b0;
    stop_d = 1'b0;
    pk = 8'h00;
    if (!busy) begin
      if (c_start) begin // R1
        pk = pick(3'd1, modeb_r, near_s, home_s, idx_s);
        state_nxt = pk[6:0];
        set_home = pk[7];
        fin = pk[0];
      end
    end else if (alm_s) begin // R11
      state_nxt = ST_IDLE;
      set_alm = 1'b1;
      stop_i = 1'b1;
      fin = 1'b1;
    end else if (emg_s) begin // R12
      state_nxt = ST_IDLE;
      set_emg = 1'b1;
      stop_i = 1'b1;
      fin = 1'b1;
    end else if (c_sdec || c_sins) begin // R2
      state_nxt = ST_IDLE;
      stop_i = c_sins;
      stop_d = c_sdec;
      fin = 1'b1;
    end else begin
      case (state_r)
        ST_S1: begin
          if (near_s) begin
            pk = pick(3'd2, modeb_r, near_s, home_s, idx_s);
          end else if (lim_fwd) begin // R17
            if (modeb_r[`AHS_ST2E]) begin
              pk = {1'b0, ST_S2A};
            end else begin
              pk = pick(3'd3, modeb_r, near_s, home_s, idx_s);
            end
          end else begin
            pk = {1'b0, ST_S1};
          end
          state_nxt = pk[6:0];
          set_home = pk[7];
          fin = pk[0];
        end
        ST_S2A: begin // R9
          if (lim_fwd) begin // R18
            state_nxt = ST_IDLE;
            set_lp = limp_s;
            set_lm = limm_s;
            stop_i = 1'b1;
            fin = 1'b1;
          end else if (home_s) begin
            state_nxt = ST_S2B;
          end
        end
        ST_S2B: begin // R9
          if (lim_fwd) begin // R18
            state_nxt = ST_IDLE;
            set_lp = limp_s;
            set_lm = limm_s;
            stop_i = 1'b1;
            fin = 1'b1;
          end else if (!home_s) begin
            state_nxt = ST_S2C;
          end
        end
        ST_S2C: begin // R9
          if (home_s) begin
            pk = pick(3'd3, modeb_r, near_s, home_s, idx_s);
            state_nxt = pk[6:0];
            set_home = pk[7];
            fin = pk[0];
          end else if (lim_fwd) begin // R18
            state_nxt = ST_S2A;
          end
        end
        ST_S3: begin // R10
          if (lim_any) begin // R13
            state_nxt = ST_IDLE;
            set_lp = limp_s;
            set_lm = limm_s;
            stop_i = ~lcfg_decel_r;
            stop_d = lcfg_decel_r;
            fin = 1'b1;
          end else if (s3_hit) begin
            pk = pick(3'd4, modeb_r, near_s, home_s, idx_s);
            state_nxt = pk[6:0];
            fin = pk[0];
          end
        end
        ST_S4: begin // R10
          if (lim_any) begin // R14
            state_nxt = ST_IDLE;
            set_lp = limp_s;
            set_lm = limm_s;
            stop_i = ~lcfg_decel_r;
            stop_d = lcfg_decel_r;
            fin = 1'b1;
          end else if (ofs_done) begin
            state_nxt = ST_IDLE; // R23
            fin = 1'b1;
            fin_s4 = 1'b1;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          fin = 1'b1;
        end
      endcase
    end
  end

  wire ofs_load = state_nxt[6] && !state_r[6];

  ahs_offset_count #(
    .W(OFS_W)
  ) u_ofs (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(ofs_load),
    .pulse_i(drive_pulse_i),
    .ofs_i(ofs_r),
    .done_o(ofs_done)
  );

  // --------------------------------------------------------------------
  // state code and read mux
  // --------------------------------------------------------------------
  reg [4:0] scode;

  always @* begin
    case (state_r)
      ST_S1: scode = `AHS_SC_S1; // R8
      ST_S2A: scode = `AHS_SC_S2A; // R9
      ST_S2B: scode = `AHS_SC_S2B; // R9
      ST_S2C: scode = `AHS_SC_S2C; // R9
      ST_S3: scode = `AHS_SC_S3; // R10
      ST_S4: scode = `AHS_SC_S4; // R10
      default: scode = `AHS_SC_IDLE; // R8 R23
    endcase
  end

  always @* begin
    rd_nxt = `AHS_ZERO16;
    if (reg_addr_i == `AHS_A_MAIN) begin
      rd_nxt[AXIS_IDX] = busy; // R3
      // transient limit hits while busy are visible too
      rd_nxt[AXIS_IDX + `AHS_ERR_SHIFT] = (|err_r) |
        (busy & lim_any);
    end else if (reg_addr_i == `AHS_A_ST1) begin
      rd_nxt[`AHS_S1_EMG:`AHS_S1_LIMP] = st1_r;
    end else if (reg_addr_i == `AHS_A_ST2) begin
      rd_nxt[7:0] = err_r; // R5
      rd_nxt[`AHS_SC_MSB:`AHS_SC_LSB] = scode; // R5
    end else if (reg_addr_i == `AHS_A_ST3) begin
      rd_nxt[`AHS_S3_DONE] = done_r;
    end
  end

  wire rd_st3 = reg_re_i && (reg_addr_i == `AHS_A_ST3);
  wire irq_set = fin && search_done_irq_enable_r;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      modeb_r <= {`AHS_MB_W{1'b0}};
      search_done_irq_enable_r <= 1'b0;
      ofs_r <= {OFS_W{1'b0}};
      lcfg_decel_r <= 1'b0;
      err_r <= 8'h00;
      st1_r <= 4'h0;
      done_r <= 1'b0;
      reg_rdata_o <= `AHS_ZERO16;
      drive_run_o <= 1'b0;
      drive_dir_o <= 1'b0;
      drive_fast_o <= 1'b0;
      stop_instant_o <= 1'b0;
      stop_decel_o <= 1'b0;
      counter_clear_o <= 1'b0;
      interrupt_out_n_o <= 1'b0;
      interrupt_oe_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (reg_we_i && reg_addr_i == `AHS_A_MODEB) begin
        modeb_r <= reg_wdata_i[`AHS_MB_W-1:0];
      end
      if (reg_we_i && reg_addr_i == `AHS_A_MODEA) begin
        search_done_irq_enable_r <= reg_wdata_i[`AHS_SEARCH_DONE_IRQ_ENABLE];
      end
      if (reg_we_i && reg_addr_i == `AHS_A_OFS) begin
        ofs_r <= reg_wdata_i[OFS_W-1:0];
      end
      if (reg_we_i && reg_addr_i == `AHS_A_LCFG) begin
        lcfg_decel_r <= reg_wdata_i[0];
      end
      // error flags: a setting event wins over any clear
      if (c_clr) begin
        err_r <= 8'h00;
        st1_r <= 4'h0;
      end else if (c_start || c_drv) begin
        err_r[`AHS_E_HOME] <= 1'b0; // R7
      end
      if (set_lp) begin
        err_r[`AHS_E_LIMP] <= 1'b1; // R13 R14 R18
        st1_r[`AHS_S1_LIMP - `AHS_S1_LIMP] <= 1'b1;
      end
      if (set_lm) begin
        err_r[`AHS_E_LIMM] <= 1'b1; // R13 R14 R18
        st1_r[`AHS_S1_LIMM - `AHS_S1_LIMP] <= 1'b1;
      end
      if (set_alm) begin
        err_r[`AHS_E_ALM] <= 1'b1; // R11
        st1_r[`AHS_S1_ALM - `AHS_S1_LIMP] <= 1'b1;
      end
      if (set_emg) begin
        err_r[`AHS_E_EMG] <= 1'b1; // R12
        st1_r[`AHS_S1_EMG - `AHS_S1_LIMP] <= 1'b1;
      end
      if (set_home) begin
        err_r[`AHS_E_HOME] <= 1'b1; // R6 R15
      end
      // done flag and interrupt: set wins over the releasing read
      if (irq_set) begin // R21
        done_r <= 1'b1;
        interrupt_oe_o <= 1'b1;
      end else if (rd_st3) begin // R21
        done_r <= 1'b0;
        interrupt_oe_o <= 1'b0;
      end
      interrupt_out_n_o <= 1'b0;
      if (reg_re_i) begin
        reg_rdata_o <= rd_nxt;
      end else begin
        reg_rdata_o <= `AHS_ZERO16;
      end
      drive_run_o <= ~state_nxt[0]; // R3
      drive_dir_o <= step_dir(state_nxt, modeb_r); // R19
      drive_fast_o <= state_nxt[1] | state_nxt[6];
      stop_instant_o <= stop_i;
      stop_decel_o <= stop_d;
      counter_clear_o <= fin_s4 & modeb_r[`AHS_COUNTER_CLEAR_AT_END]; // R20
    end
  end

endmodule // ahs_sequencer
`default_nettype wire

// [ahs_sequencer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ahs_sequencer_props (
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [3:0] reg_addr_i, // register address
  input wire logic [15:0] reg_wdata_i, // write data
  input wire logic reg_we_i, // write strobe
  input wire logic reg_re_i, // read strobe
  input wire logic [15:0] reg_rdata_o, // read data
  input wire logic servo_alarm_i, // servo alarm
  input wire logic emergency_stop_input_i, // emergency stop
  input wire logic drive_run_o, // motion request
  input wire logic stop_instant_o, // instant stop pulse
  input wire logic stop_decel_o, // decelerating stop pulse
  input wire logic counter_clear_o, // counter clear pulse
  input wire logic interrupt_out_n_o, // interrupt pin level
  input wire logic interrupt_oe_o // interrupt pin driven
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_start_by_cmd: assert property ($rose(drive_run_o) |->
    ($past(reg_we_i) && $past(reg_wdata_i[6:0]) == 7'h62) ||
    ($past(reg_we_i, 2) && $past(reg_wdata_i[6:0], 2) == 7'h62))
    else $error("motion began without a start command");
  a_instant_at_end: assert property (stop_instant_o |->
    !drive_run_o && $past(drive_run_o) ##1 !stop_instant_o)
    else $error("instant stop pulse not at search end");
  a_decel_at_end: assert property (stop_decel_o |->
    !drive_run_o && $past(drive_run_o) ##1 !stop_decel_o)
    else $error("decelerating stop pulse not at search end");
  a_clear_at_end: assert property (counter_clear_o |->
    !drive_run_o && $past(drive_run_o) ##1 !counter_clear_o)
    else $error("counter clear pulse not at search end");
  a_read_idle: assert property (!$past(reg_re_i) |->
    reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  a_busy_read: assert property ($past(reg_re_i) &&
    $past(reg_addr_i) == 4'h0 |-> reg_rdata_o[0] == $past(drive_run_o))
    else $error("busy bit differs from motion state");
  a_code_idle: assert property ($past(reg_re_i) && !$past(drive_run_o) &&
    $past(reg_addr_i) == 4'h2 |-> reg_rdata_o[12:8] == 5'h00)
    else $error("state code not zero while idle");
  a_code_busy: assert property ($past(reg_re_i) && $past(drive_run_o) &&
    $past(reg_addr_i) == 4'h2 |->
    reg_rdata_o[12:8] inside {5'h03, 5'h08, 5'h0C, 5'h0F, 5'h14, 5'h19})
    else $error("state code not a step code while busy");
  a_alarm_halt: assert property (servo_alarm_i [*7] |-> !drive_run_o)
    else $error("motion continues under alarm");
  a_emg_halt: assert property (emergency_stop_input_i [*7] |-> !drive_run_o)
    else $error("motion continues under emergency stop");
  a_irq_low: assert property (interrupt_oe_o |-> !interrupt_out_n_o)
    else $error("interrupt pin driven high");
  a_irq_at_end: assert property ($rose(interrupt_oe_o) |-> !drive_run_o)
    else $error("interrupt raised while search runs");
endmodule // ahs_sequencer_props

bind ahs_sequencer ahs_sequencer_props ahs_sequencer_props_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .servo_alarm_i(servo_alarm_i),
  .emergency_stop_input_i(emergency_stop_input_i),
  .drive_run_o(drive_run_o), .stop_instant_o(stop_instant_o),
  .stop_decel_o(stop_decel_o), .counter_clear_o(counter_clear_o),
  .interrupt_out_n_o(interrupt_out_n_o), .interrupt_oe_o(interrupt_oe_o));
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic slow = 1'b0;
  // emg, alarm, minus, plus, index, home, near
  logic [6:0] sv = 7'h00;
  logic [15:0] rdata;
  logic pulse, run, dir, fast, sti, std, clr, irq_n, irq_oe;
  logic sti_s = 1'b0;
  logic std_s = 1'b0;
  logic clr_s = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 clk_i = ~clk_i;

  ahs_sequencer ahs_sequencer_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .near_home_input_i(sv[0]),
    .home_position_input_i(sv[1]), .encoder_index_input_i(sv[2]),
    .plus_limit_input_i(sv[3]), .minus_limit_input_i(sv[4]),
    .servo_alarm_i(sv[5]), .emergency_stop_input_i(sv[6]),
    .drive_pulse_i(pulse), .drive_run_o(run), .drive_dir_o(dir),
    .drive_fast_o(fast), .stop_instant_o(sti), .stop_decel_o(std),
    .counter_clear_o(clr), .interrupt_out_n_o(irq_n),
    .interrupt_oe_o(irq_oe));
  ahs_pulse_model ahs_pulse_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .run_i(run), .slow_i(slow), .pulse_o(pulse));

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (sti === 1'b1) sti_s <= 1'b1;
    if (std === 1'b1) std_s <= 1'b1;
    if (clr === 1'b1) clr_s <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic ck(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  // read one word and compare the masked bits
  task automatic rk(input logic [3:0] a, input logic [15:0] m,
                    input logic [15:0] e);
    @(posedge clk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1 ck(e, rdata & m);
  endtask

  // sensor change, then room for the input filter and the decision
  task automatic sn(input int b, input logic v);
    @(posedge clk_i);
    sv[b] <= v;
    repeat (7) @(posedge clk_i);
    #1;
  endtask

  task automatic wend;
    repeat (2) @(posedge clk_i);
    for (int n = 0; n < 400 && run !== 1'b0; n++) @(posedge clk_i);
    #1;
  endtask

  task automatic go(input logic [15:0] m);
    wr(4'h1, m);
    sti_s = 1'b0;
    std_s = 1'b0;
    clr_s = 1'b0;
    wr(4'h0, 16'h0162);
  endtask

  task automatic calm;
    @(posedge clk_i);
    sv <= 7'h00;
    repeat (7) @(posedge clk_i);
    wr(4'h0, 16'h0125);
  endtask

  task automatic t_normal;
    slow <= 1'b1;
    wr(4'h3, 16'h0028);
    wr(4'h2, 16'h0020);
    go(16'h0155);
    rk(4'h2, 16'h1F00, 16'h0300);
    ck(16'h0002, {14'h0, fast, dir});
    sn(0, 1'b1);
    rk(4'h2, 16'h1F00, 16'h0F00);
    sn(1, 1'b1);
    rk(4'h2, 16'h1F00, 16'h1400);
    sn(2, 1'b1);
    rk(4'h2, 16'h1F00, 16'h1900);
    rk(4'h0, 16'h0001, 16'h0001);
    wend;
    ck(16'h0003, {13'h0, irq_n, clr_s, irq_oe});
    rk(4'h0, 16'h0011, 16'h0000);
    rk(4'h3, 16'h0100, 16'h0100);
    ck(16'h0000, {15'h0, irq_oe});
    slow <= 1'b0;
    calm;
  endtask

  task automatic t_home;
    sn(0, 1'b1);
    go(16'h000F);
    rk(4'h2, 16'h1F00, 16'h0F00);
    ck(16'h0001, {15'h0, dir});
    sn(4, 1'b1);
    rk(4'h2, 16'h1F00, 16'h0800);
    ck(16'h0000, {15'h0, dir});
    sn(4, 1'b0);
    sn(1, 1'b1);
    rk(4'h2, 16'h1F00, 16'h0C00);
    sn(3, 1'b1);
    wend;
    rk(4'h2, 16'h1F0C, 16'h0004);
    rk(4'h1, 16'h3000, 16'h1000);
    rk(4'h0, 16'h0011, 16'h0010);
    calm;
  endtask

  task automatic t_step1;
    for (int i = 0; i < 2; i++) begin
      go(16'h0005);
      rk(4'h2, 16'h1F00, 16'h0300);
      sn(3, 1'b1);
      rk(4'h2, 16'h1F00, 16'h0800);
      wr(4'h0, i ? 16'h0127 : 16'h0126);
      rk(4'h2, 16'h1F00, 16'h0000);
      ck(i ? 16'h0002 : 16'h0001, {14'h0, sti_s, std_s});
      calm;
    end
  endtask

  task automatic t_index;
    sn(2, 1'b1);
    go(16'h0010);
    wend;
    rk(4'h2, 16'h1F80, 16'h0080);
    rk(4'h0, 16'h0011, 16'h0010);
    wr(4'h0, 16'h0125);
    rk(4'h2, 16'h0080, 16'h0000);
    go(16'h0010);
    wend;
    wr(4'h0, 16'h0120);
    rk(4'h2, 16'h0080, 16'h0000);
    rk(4'hF, 16'hFFFF, 16'h0000);
    calm;
  endtask

  task automatic t_fault;
    for (int i = 0; i < 2; i++) begin
      go(16'h0001);
      sn(5 + i, 1'b1);
      ck(16'h0002, {14'h0, sti_s, run});
      rk(4'h2, 16'h0030, i ? 16'h0020 : 16'h0010);
      rk(4'h1, 16'hC000, i ? 16'h8000 : 16'h4000);
      calm;
    end
  endtask

  task automatic t_limit;
    wr(4'h4, 16'h0001);
    go(16'h0010);
    rk(4'h2, 16'h1F00, 16'h1400);
    sn(4, 1'b1);
    ck(16'h0001, {14'h0, run, std_s});
    rk(4'h2, 16'h000C, 16'h0008);
    rk(4'h1, 16'h3000, 16'h2000);
    calm;
    go(16'h0040);
    sn(3, 1'b1);
    ck(16'h0001, {14'h0, run, std_s});
    rk(4'h2, 16'h000C, 16'h0004);
    calm;
    go(16'h0210);
    sn(2, 1'b1);
    rk(4'h2, 16'h1F00, 16'h1400);
    sn(1, 1'b1);
    rk(4'h0, 16'h0001, 16'h0000);
    calm;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_normal;
    t_home;
    t_step1;
    t_index;
    t_fault;
    t_limit;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
